// file: dv/gate_protect_regs_test.sv
// Self-checking bench for the protection register bank
module gate_protect_regs_test;
  import gate_protect_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int PC = 20;
  localparam int OC = 8;
  logic        clk, resetn, sclk, cs_n, mosi, miso, miso_oe, sfl, rd_valid;
  logic        ub_s, ub_d, fb_s, fb_d, nvm_strobe, gate_en;
  logic [23:0] rd_data, nvm_data, nv_last, cfg, flags;
  sense_t      sense;
  drive_t      drv;
  analog_sel_t asel;
  logic [23:0] exp_q[$];
  int          error_cnt, n_tests, seed, b;
  int          n_strobe = 0;
  int          codes[3] = '{0, 1, 15};

  gate_protect_regs #(.PROG_CYC(PC), .OC_CYC(OC)) gate_protect_regs_i (
    .clk(clk), .resetn(resetn), .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso),
    .miso_oe(miso_oe), .supply_fault_line(sfl), .sense_pins(sense),
    .user_bank_single_err(ub_s), .user_bank_double_err(ub_d),
    .factory_bank_single_err(fb_s), .factory_bank_double_err(fb_d),
    .nvm_write_strobe(nvm_strobe), .nvm_write_data(nvm_data), .drive(drv),
    .analog_sel(asel), .gate_enable(gate_en));
  spi_host_model spi_host_model_i (
    .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso), .rd_valid(rd_valid), .rd_data(rd_data));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic check(input logic [23:0] got, input logic [23:0] exp, input string m);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic rng(input int v, lo, hi, input string m);
    n_tests++;
    if (v < lo || v > hi) begin
      error_cnt++;
      $display("mismatch at %0t: %s at %0d not in %0d..%0d", $time, m, v, lo, hi);
    end
  endtask
  task automatic wr(input logic [1:0] a, input logic [23:0] d);
    spi_host_model_i.xfer(a, 1'b1, d);
  endtask
  // Expected value is queued first; the read watcher compares it
  task automatic rd(input logic [1:0] a, input logic [23:0] e);
    exp_q.push_back(e);
    spi_host_model_i.xfer(a, 1'b0, 24'h00_0000);
  endtask
  always @(posedge rd_valid) begin
    if (exp_q.size() == 0) check(24'h00_0001, 24'h00_0000, "unexpected read");
    else check(rd_data, exp_q.pop_front(), "read");
  end
  always @(posedge clk) begin
    if (nvm_strobe === 1'b1) begin
      n_strobe <= n_strobe + 1;
      nv_last  <= nvm_data;
    end
  end
  // Gate on with given pins held; indices count edges after the command edge, -1 is never
  task automatic gc(input logic [23:0] c, input logic [4:0] s, input int plo, phi, slo, shi);
    int tp, ts;
    wr(ADDR_CONFIG, c);
    @(posedge clk) sense <= s;
    @(posedge clk) sense.gate_cmd <= 1'b1;
    tp = -1;
    ts = -1;
    for (int i = 0; i < 700; i++) begin
      @(posedge clk);
      #1;
      if (drv.plateau === 1'b1 && tp < 0) tp = i;
      if (drv.soft_shutdown === 1'b1 && ts < 0) ts = i;
    end
    check(24'(drv.full_on), 24'((phi < 0 && shi < 0) ? 1 : 0), "full drive");
    check(24'(drv.fault), 24'(shi >= 0), "fault flag");
    @(posedge clk) sense <= '0;
    repeat (6) @(posedge clk);
    rng(tp, plo, phi, "plateau");
    rng(ts, slo, shi, "shutdown");
  endtask
  task automatic summarize;
    if (exp_q.size() != 0) error_cnt++;
    $display("counts: %0d compares, %0d mismatches", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #400_000;
    error_cnt++;
    $display("mismatch at %0t: watchdog expired", $time);
    summarize();
  end
  initial begin
    seed   = 2996;
    resetn = 1'b1;
    sfl    = 1'b0;
    sense  = '0;
    {fb_d, fb_s, ub_d, ub_s} = 4'h0;
    // Reset falls after time zero so the link toggle's clear edge is never lost
    #1 resetn = 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    repeat (4) @(posedge clk);
    check(24'(gate_en), 24'h00_0001, "gate idle");
    check(24'(miso_oe), 24'h00_0000, "link released");
    rd(ADDR_CONFIG, CONFIG_RESET);
    rd(ADDR_CTRL, 24'h00_0000);
    rd(2'h0, 24'h00_0000);
    rd(2'h3, 24'h00_0000);
    $display("test reset done");
    cfg = 24'($random(seed));
    wr(ADDR_CONFIG, cfg);
    wr(2'h3, ~cfg);
    @(posedge clk) sfl <= 1'b1;
    wr(ADDR_CONFIG, ~cfg);
    @(posedge clk) sfl <= 1'b0;
    fork
      rd(ADDR_CONFIG, cfg & CONFIG_MASK);
      begin
        #600;
        check(24'(gate_en), 24'h00_0000, "gate in frame");
        check(24'(miso_oe), 24'h00_0001, "link driven");
      end
    join
    check(24'(asel), 24'h00_0000, "stored governs");
    wr(ADDR_CTRL, 24'h00_0001);
    wr(ADDR_CONFIG, 24'h00_8003);
    check(24'(asel), 24'h00_0007, "trial select");
    wr(ADDR_CONFIG, 24'h00_0002);
    check(24'(asel), 24'h00_0002, "trial select");
    $display("test access done");
    for (int j = 0; j < 3; j++) begin
      b = (BLANK_NS[codes[j]] * CLK_MHZ + 999) / 1000;
      gc(24'h00_0001 | (24'(codes[j]) << 7), 5'b01000, b, b + 7, b + OC, b + OC + 8);
    end
    gc(24'h00_4000, 5'b01000, -1, -1, 0, 7);
    gc(24'h00_2000, 5'b01000, -1, -1, OC, OC + 8);
    gc(24'h00_0F80, 5'b01000, 0, 7, -1, 700);
    gc(24'h00_0000, 5'b00100, 0, 7, -1, -1);
    gc(24'h00_1000, 5'b00100, -1, -1, -1, -1);
    gc(24'h00_0000, 5'b00010, -1, 700, 0, 7);
    gc(24'h00_0000, 5'b00001, -1, 700, 0, 7);
    gc(24'h01_0000, 5'b00011, -1, -1, -1, -1);
    $display("test protection done");
    wr(ADDR_CONFIG, 24'h01_8001);
    wr(ADDR_CTRL, 24'h00_0003);
    rd(ADDR_CTRL, 24'h00_0003);
    rd(ADDR_CTRL, 24'h00_0001);
    check(24'(n_strobe), 24'h00_0001, "strobe count");
    check(nv_last, 24'h01_8001, "stored word");
    $display("test programming done");
    @(posedge clk) sense <= 5'b10000;
    flags = 24'h00_0001;
    for (int k = 0; k < 4; k++) begin
      wr(ADDR_CONFIG, (k > 0) ? 24'h00_0040 : 24'h00_0000);
      @(posedge clk) {fb_d, fb_s, ub_d, ub_s} <= 4'(1 << k);
      @(posedge clk) {fb_d, fb_s, ub_d, ub_s} <= 4'h0;
      repeat (4) @(posedge clk);
      #1;
      check(24'({drv.soft_shutdown, drv.fault}), (k > 0) ? 24'h00_0003 : 24'h00_0000, "ecc stop");
      flags = flags | (24'h00_0004 << k);
      rd(ADDR_CTRL, flags);
    end
    @(posedge clk) sense <= '0;
    wr(ADDR_CTRL, 24'h00_0000);
    rd(ADDR_CTRL, 24'h00_0000);
    check(24'(asel), 24'h00_0005, "reload");
    $display("test ecc done");
    summarize();
  end
endmodule

// file: dv/spi_host_model.sv
// Host model: mode 0 / phase 1 serial master that runs one frame per call
module spi_host_model (
  output logic        sclk,
  output logic        cs_n,
  output logic        mosi,
  input  wire logic   miso,
  output logic        rd_valid,
  output logic [23:0] rd_data
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    sclk     = 1'b0;
    cs_n     = 1'b0;
    mosi     = 1'b0;
    rd_valid = 1'b0;
    rd_data  = 24'h00_0000;
    // Chip select rises just after time zero so the link clear is a real edge
    #1 cs_n = 1'b1;
  end
  // Idle data line keeps moving so a stale bit is never mistaken for data
  always #37 if (cs_n) mosi = ~mosi;
  task automatic xfer(input logic [1:0] addr, input logic wr, input logic [23:0] wdata);
    logic [26:0] frame;
    logic [23:0] rx;
    frame = {addr, wr, wdata};
    rx    = 24'h00_0000;
    cs_n  = 1'b0;
    #43;
    for (int i = 26; i >= 0; i--) begin
      sclk = 1'b1;
      mosi = frame[i];
      #32;
      sclk = 1'b0;
      if (i < 24) rx[i] = miso;
      #32;
    end
    cs_n = 1'b1;
    if (!wr) begin
      rd_data  = rx;
      rd_valid = 1'b1;
      #8;
      rd_valid = 1'b0;
    end
    #40;
  endtask
endmodule

// file: include/gate_protect_pkg.sv
// Constants, carriers and states shared by the protection register bank
package gate_protect_pkg;
  localparam int          WORD_W       = 24;
  localparam int          FRAME_BITS   = 27;
  localparam logic [1:0]  ADDR_CONFIG  = 2'h1;
  localparam logic [1:0]  ADDR_CTRL    = 2'h2;
  localparam logic [23:0] CONFIG_MASK  = 24'h01_FFC3;
  localparam logic [23:0] CTRL_MASK    = 24'h00_003F;
  localparam logic [23:0] CONFIG_RESET = 24'h00_0000;
  // Configuration word fields
  localparam int CFG_OT_DISABLE   = 16;
  localparam int CFG_OT_SELECT    = 15;
  localparam int CFG_OC_IMMEDIATE = 14;
  localparam int CFG_OC_NO_PLAT   = 13;
  localparam int CFG_COLD_DISABLE = 12;
  localparam int CFG_PLAT_MASKING = 11;
  localparam int CFG_BLANK_LSB    = 7;
  localparam int CFG_ECC_SHUTDOWN = 6;
  localparam int CFG_FIXED_REF    = 1;
  localparam int CFG_PWM_FAST     = 0;
  // Control/status word fields
  localparam int CTL_B2_DOUBLE = 5;
  localparam int CTL_B2_SINGLE = 4;
  localparam int CTL_B1_DOUBLE = 3;
  localparam int CTL_B1_SINGLE = 2;
  localparam int CTL_BUSY      = 1;
  localparam int CTL_TRIAL_SETTINGS_ENABLE  = 0;
  // Timing
  localparam int CLK_MHZ        = 125;
  localparam int PROG_TIME_MS   = 40;
  localparam int PROG_CYCLES    = PROG_TIME_MS * CLK_MHZ * 1000;
  localparam int OC_DETECT_NS   = 2000;
  localparam int OC_DETECT_CYC  = OC_DETECT_NS * CLK_MHZ / 1000;
  localparam int BLANK_CNT_W    = 10;
  localparam int BLANK_NS [16]  = '{0, 360, 560, 770, 970, 1170, 1570, 1970,
                                    2370, 2780, 3180, 3580, 3980, 4390, 4790, 5190};

  typedef struct packed {
    logic gate_cmd;
    logic oc_detect;
    logic cold_detect;
    logic ot_sense_a;
    logic ot_sense_b;
  } sense_t;

  typedef struct packed {
    logic full_on;
    logic plateau;
    logic soft_shutdown;
    logic fault;
  } drive_t;

  typedef struct packed {
    logic threshold_high;
    logic fixed_reference;
    logic pwm_fast;
  } analog_sel_t;

  typedef enum logic [2:0] {OC_OFF, OC_BLANK, OC_ON, OC_PLATEAU, OC_SHUTDOWN} oc_state_t;

  // Least time, rounded up to whole cycles
  function automatic logic [BLANK_CNT_W-1:0] blank_cycles(input logic [3:0] code);
    blank_cycles = BLANK_CNT_W'((BLANK_NS[code] * CLK_MHZ + 999) / 1000);
  endfunction
endpackage

// file: rtl/gate_protect_regs.sv
// Protection configuration/status register bank with serial access and protection sequencing
// Summary of operation
// - Config bit 16 set suppresses overtemperature faults; clear, either sensor faults.
// - Config bit 15 picks the higher overtemperature threshold pair.
// - Config bit 14 makes overcurrent go straight to soft shutdown, blanking kept.
// - Config bit 13 skips plateau drive until detect delay ends, then fault.
// - Config bit 12 clear: cold indication makes on-commands drive plateau.
// - Config bit 11 set: overcurrent during blanking gives plateau drive.
// - Config bits 10:7 set blanking after turn-on; overcurrent ignored meanwhile unless bit 11 set.
// - Blanking code maps 0 to zero, 1 to 0.36 us, up to 5.19 us.
// - Config bit 6 set: any ECC error causes soft shutdown and fault.
// - Config bit 1 clear: reference tracks sensor A; set: fixed reference.
// - Config bit 0 picks 50 kHz temperature PWM, else 10 kHz.
// - Control word bits 5..2 hold bank error flags; bits 23:6 reserved.
// - Bank 2 flags cover factory trim; bank 1 flags cover user trim.
// - Single-bit errors are corrected and flagged in the single flag.
// - Double-bit errors are only detected and flagged in the double flag.
// - Writing busy starts programming; hardware clears it within 40 ms.
// - Simulate-trim clear: stored values govern; set: written values act.
// - Frames are mode 0/phase 1: two address bits, write flag, 24 data MSB first.
// - Writes act only with chip select and supply fault low, reads need chip select only; gate off meanwhile.
module gate_protect_regs
  import gate_protect_pkg::*;
#(
  parameter int PROG_CYC = PROG_CYCLES,
  parameter int OC_CYC   = OC_DETECT_CYC
) (
  input  wire logic                      clk,
  input  wire logic                      resetn,
  input  wire logic                      sclk,
  input  wire logic                      cs_n,
  input  wire logic                      mosi,
  output logic                           miso,
  output logic                           miso_oe,
  input  wire logic                      supply_fault_line,
  input  wire gate_protect_pkg::sense_t  sense_pins,
  input  wire logic                      user_bank_single_err,
  input  wire logic                      user_bank_double_err,
  input  wire logic                      factory_bank_single_err,
  input  wire logic                      factory_bank_double_err,
  output logic                           nvm_write_strobe,
  output logic [WORD_W-1:0]              nvm_write_data,
  output gate_protect_pkg::drive_t       drive,
  output gate_protect_pkg::analog_sel_t  analog_sel,
  output logic                           gate_enable
);
  import gate_protect_pkg::*;

  // Link domain: frame is cleared by chip select, as sclk stops between frames
  logic [4:0]            bit_cnt_q;
  logic [FRAME_BITS-1:0] shift_q;
  logic [FRAME_BITS-1:0] frame_q;
  logic [2:0]            hdr_q;
  logic                  frame_tgl_q;
  logic [WORD_W-1:0]     rd_shadow_q [4];

  always_ff @(negedge sclk or posedge cs_n) begin
    if (cs_n) begin
      bit_cnt_q <= 5'h00;
      shift_q   <= '0;
    end else begin
      shift_q   <= {shift_q[FRAME_BITS-2:0], mosi};
      bit_cnt_q <= (bit_cnt_q == 5'(FRAME_BITS - 1)) ? 5'h00 : bit_cnt_q + 5'h01;
    end
  end

  // Completed frame survives chip select so the core can pick it up later
  // Address and write flag are held apart, as the shifter moves on under the read data
  always_ff @(negedge sclk) begin
    if (!cs_n && bit_cnt_q == 5'h02) begin
      hdr_q <= {shift_q[1:0], mosi};
    end
    if (!cs_n && bit_cnt_q == 5'(FRAME_BITS - 1)) begin
      frame_q <= {shift_q[FRAME_BITS-2:0], mosi};
    end
  end

  // Toggle needs a known start for the core's edge detector; sclk is idle during reset
  always_ff @(negedge sclk or negedge resetn) begin
    if (!resetn) begin
      frame_tgl_q <= 1'b0;
    end else if (!cs_n && bit_cnt_q == 5'(FRAME_BITS - 1)) begin
      frame_tgl_q <= ~frame_tgl_q;
    end
  end

  // Read data is launched on rising edges once address and write flag are in
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      miso    <= 1'b0;
      miso_oe <= 1'b0;
    end else begin
      miso_oe <= 1'b1;
      if (bit_cnt_q >= 5'h03 && !hdr_q[0]) begin
        miso <= rd_shadow_q[hdr_q[2:1]][5'(FRAME_BITS - 1) - bit_cnt_q];
      end else begin
        miso <= 1'b0;
      end
    end
  end

  // Core domain: pin synchronisers
  logic [2:0]   tgl_sync_q;
  logic [1:0]   cs_sync_q;
  logic [1:0]   uv_sync_q;
  sense_t       sense_meta_q;
  sense_t       sense_q;
  logic         frame_done;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      tgl_sync_q   <= 3'h0;
      cs_sync_q    <= 2'h3;
      uv_sync_q    <= 2'h3;
      sense_meta_q <= '0;
      sense_q      <= '0;
    end else begin
      tgl_sync_q   <= {tgl_sync_q[1:0], frame_tgl_q};
      cs_sync_q    <= {cs_sync_q[0], cs_n};
      uv_sync_q    <= {uv_sync_q[0], supply_fault_line};
      sense_meta_q <= sense_pins;
      sense_q      <= sense_meta_q;
    end
  end

  assign frame_done = tgl_sync_q[2] ^ tgl_sync_q[1];

  // Registers
  logic [WORD_W-1:0] config_q;
  logic [WORD_W-1:0] nv_config_q;
  logic [WORD_W-1:0] eff_config;
  logic              trial_settings_enable_q;
  logic              busy_q;
  logic [31:0]       prog_cnt_q;
  logic [3:0]        ecc_flags_q;
  logic              wr_ok;
  logic [1:0]        wr_addr;
  logic [WORD_W-1:0] wr_data;
  logic              reload;

  assign wr_addr = frame_q[FRAME_BITS-1:FRAME_BITS-2];
  assign wr_data = frame_q[WORD_W-1:0];
  assign wr_ok   = frame_done && frame_q[WORD_W] && !uv_sync_q[1];
  assign reload  = wr_ok && wr_addr == ADDR_CTRL && trial_settings_enable_q && !wr_data[CTL_TRIAL_SETTINGS_ENABLE];
  assign eff_config = trial_settings_enable_q ? config_q : nv_config_q;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      config_q   <= CONFIG_RESET;
      trial_settings_enable_q <= 1'b0;
    end else if (wr_ok && wr_addr == ADDR_CONFIG) begin
      config_q <= wr_data & CONFIG_MASK;
    end else if (reload) begin
      config_q   <= nv_config_q;
      trial_settings_enable_q <= 1'b0;
    end else if (wr_ok && wr_addr == ADDR_CTRL) begin
      trial_settings_enable_q <= wr_data[CTL_TRIAL_SETTINGS_ENABLE];
    end
  end

  // Programming copies the written word into storage; the wait models the cell write
  always_ff @(posedge clk) begin
    if (!resetn) begin
      busy_q           <= 1'b0;
      prog_cnt_q       <= 32'h0000_0000;
      nv_config_q      <= CONFIG_RESET;
      nvm_write_strobe <= 1'b0;
      nvm_write_data   <= '0;
    end else begin
      nvm_write_strobe <= 1'b0;
      if (!busy_q && wr_ok && wr_addr == ADDR_CTRL && wr_data[CTL_BUSY]) begin
        busy_q         <= 1'b1;
        prog_cnt_q     <= 32'(PROG_CYC - 1);
        nvm_write_data <= config_q;
      end else if (busy_q) begin
        if (prog_cnt_q == 32'h0000_0000) begin
          busy_q           <= 1'b0;
          nv_config_q      <= nvm_write_data;
          nvm_write_strobe <= 1'b1;
        end else begin
          prog_cnt_q <= prog_cnt_q - 32'h0000_0001;
        end
      end
    end
  end

  // Decoder events set sticky flags; a new error in the reload cycle wins over the clear
  always_ff @(posedge clk) begin
    if (!resetn) begin
      ecc_flags_q <= 4'h0;
    end else begin
      ecc_flags_q <= (reload ? 4'h0 : ecc_flags_q) |
                     {factory_bank_double_err, factory_bank_single_err,
                      user_bank_double_err, user_bank_single_err};
    end
  end

  // Snapshot for the link only moves while no frame is open, so it is stable to sclk
  always_ff @(posedge clk) begin
    if (!resetn) begin
      for (int i = 0; i < 4; i++) begin
        rd_shadow_q[i] <= '0;
      end
    end else if (cs_sync_q[1]) begin
      rd_shadow_q[0]         <= '0;
      rd_shadow_q[ADDR_CONFIG] <= config_q & CONFIG_MASK;
      rd_shadow_q[ADDR_CTRL]   <= {18'h0_0000, ecc_flags_q, busy_q, trial_settings_enable_q} & CTRL_MASK;
      rd_shadow_q[3]         <= '0;
    end
  end

  // Protection sequencing
  oc_state_t                oc_state_q;
  logic [BLANK_CNT_W-1:0]   blank_cnt_q;
  logic [31:0]              oc_cnt_q;
  logic                     ecc_fault;
  logic                     ot_fault;
  logic                     cold_mode;

  assign ecc_fault = eff_config[CFG_ECC_SHUTDOWN] && (ecc_flags_q != 4'h0);
  assign ot_fault  = !eff_config[CFG_OT_DISABLE] && (sense_q.ot_sense_a || sense_q.ot_sense_b);
  assign cold_mode = sense_q.cold_detect && !eff_config[CFG_COLD_DISABLE];

  always_ff @(posedge clk) begin
    if (!resetn) begin
      oc_state_q  <= OC_OFF;
      blank_cnt_q <= '0;
      oc_cnt_q    <= 32'h0000_0000;
    end else if (ecc_fault || ot_fault) begin
      oc_state_q <= OC_SHUTDOWN;
    end else begin
      unique case (oc_state_q)
        OC_OFF: begin
          if (sense_q.gate_cmd) begin
            blank_cnt_q <= blank_cycles(eff_config[CFG_BLANK_LSB +: 4]);
            oc_state_q  <= OC_BLANK;
          end
        end
        OC_BLANK: begin
          if (!sense_q.gate_cmd) begin
            oc_state_q <= OC_OFF;
          end else if (blank_cnt_q == '0) begin
            oc_state_q <= OC_ON;
          end else begin
            blank_cnt_q <= blank_cnt_q - BLANK_CNT_W'(1);
            if (sense_q.oc_detect && eff_config[CFG_PLAT_MASKING]) begin
              oc_state_q <= OC_PLATEAU;
              oc_cnt_q   <= 32'(OC_CYC - 1);
            end
          end
        end
        OC_ON: begin
          if (!sense_q.gate_cmd) begin
            oc_state_q <= OC_OFF;
          end else if (sense_q.oc_detect) begin
            oc_state_q <= eff_config[CFG_OC_IMMEDIATE] ? OC_SHUTDOWN : OC_PLATEAU;
            oc_cnt_q   <= 32'(OC_CYC - 1);
          end
        end
        OC_PLATEAU: begin
          if (!sense_q.oc_detect) begin
            oc_state_q <= sense_q.gate_cmd ? OC_ON : OC_OFF;
          end else if (oc_cnt_q == 32'h0000_0000) begin
            oc_state_q <= OC_SHUTDOWN;
          end else begin
            oc_cnt_q <= oc_cnt_q - 32'h0000_0001;
          end
        end
        OC_SHUTDOWN: begin
          // Latched until the gate command is released
          if (!sense_q.gate_cmd) begin
            oc_state_q <= OC_OFF;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      drive       <= '0;
      analog_sel  <= '0;
      gate_enable <= 1'b0;
    end else begin
      gate_enable                <= cs_sync_q[1];
      analog_sel.threshold_high  <= eff_config[CFG_OT_SELECT];
      analog_sel.fixed_reference <= eff_config[CFG_FIXED_REF];
      analog_sel.pwm_fast        <= eff_config[CFG_PWM_FAST];
      drive.fault         <= oc_state_q == OC_SHUTDOWN;
      drive.soft_shutdown <= oc_state_q == OC_SHUTDOWN;
      drive.plateau       <= (oc_state_q == OC_PLATEAU && !eff_config[CFG_OC_NO_PLAT]) ||
                             ((oc_state_q == OC_ON || oc_state_q == OC_BLANK) && cold_mode);
      drive.full_on       <= (oc_state_q == OC_ON || oc_state_q == OC_BLANK) && !cold_mode;
    end
  end

  // Checks
  // Busy length counted apart from the down-counter, so the bound does not hold by construction
  logic [31:0] busy_len_q;

  always_ff @(posedge clk) begin
    if (!resetn || !busy_q) begin
      busy_len_q <= 32'h0000_0000;
    end else begin
      busy_len_q <= busy_len_q + 32'h0000_0001;
    end
  end

  sequence s_prog_start;
    !busy_q && wr_ok && wr_addr == ADDR_CTRL && wr_data[CTL_BUSY];
  endsequence
  sequence s_busy_then_idle;
    busy_q ##1 !busy_q;
  endsequence

  chk_busy_sets: assert property (@(posedge clk) disable iff (!resetn) s_prog_start |=> busy_q)
    else $error("busy not set by program request");
  chk_busy_clears: assert property (@(posedge clk) disable iff (!resetn)
    s_busy_then_idle |-> nvm_write_strobe)
    else $error("busy cleared without storage write");
  chk_busy_bound: assert property (@(posedge clk) disable iff (!resetn)
    busy_q |-> busy_len_q < 32'(PROG_CYC))
    else $error("programming wait exceeds limit");
  chk_ot_fault: assert property (@(posedge clk) disable iff (!resetn)
    ot_fault && !ecc_fault |=> oc_state_q == OC_SHUTDOWN ##1 drive.fault)
    else $error("overtemperature did not shut down");
  chk_ecc_sticky: assert property (@(posedge clk) disable iff (!resetn)
    ecc_flags_q[0] && !reload |=> ecc_flags_q[0])
    else $error("ECC flag lost without reload");
  chk_ecc_set: assert property (@(posedge clk) disable iff (!resetn)
    factory_bank_double_err |=> ecc_flags_q[3])
    else $error("double error not flagged");
  chk_oc_immediate: assert property (@(posedge clk) disable iff (!resetn)
    oc_state_q == OC_ON && sense_q.gate_cmd && sense_q.oc_detect && eff_config[CFG_OC_IMMEDIATE]
    && !ecc_fault && !ot_fault |=> oc_state_q == OC_SHUTDOWN)
    else $error("immediate shutdown skipped");
  chk_gate_off_cs: assert property (@(posedge clk) disable iff (!resetn)
    !cs_sync_q[1] |=> !gate_enable)
    else $error("gate enabled during serial access");
  chk_reserved_zero: assert property (@(posedge clk) disable iff (!resetn)
    (config_q & ~CONFIG_MASK) == 24'h00_0000)
    else $error("reserved configuration bit set");
  chk_pwm_select: assert property (@(posedge clk) disable iff (!resetn)
    ##1 analog_sel.pwm_fast == $past(eff_config[CFG_PWM_FAST]))
    else $error("PWM select does not follow settings");
endmodule
